// ===== shared/pbh_pkg.sv
// Package for the function header and BAR decode block: offsets, fields, reset values, limits.
`default_nettype none
package pbh_pkg;
    // --------------------------------------------------------------------
    // Register offsets (byte addresses on APB).
    // --------------------------------------------------------------------
    localparam logic [7:0] OFF_IDENT = 8'h00;        // Device id and vendor id, read-only.
    localparam logic [7:0] OFF_CLASS = 8'h04;        // Revision and class code, read-only.
    localparam logic [7:0] OFF_CIS = 8'h08;          // CardBus CIS pointer, read-only.
    localparam logic [7:0] OFF_CAPS = 8'h0C;         // Capability and device capability fields.
    localparam logic [7:0] OFF_DEVCTL = 8'h10;       // Device control, read-write.
    localparam logic [7:0] OFF_MODE = 8'h14;         // Port mode, read-write.
    localparam logic [7:0] OFF_SUBSYS = 8'h18;       // Subsystem vendor and subsystem ids.
    localparam logic [7:0] OFF_BAR0 = 8'h20;         // BAR0 base, BARn at OFF_BAR0 + 4*n.
    localparam logic [7:0] OFF_BARCFG0 = 8'h40;      // BAR0 config, BARn config at + 4*n.
    localparam logic [7:0] OFF_ROM = 8'h60;          // Expansion ROM base and enable.
    localparam logic [7:0] OFF_ROMCFG = 8'h64;       // Expansion ROM size exponent.
    localparam logic [7:0] OFF_HIT = 8'h68;          // Decoder query address low.
    localparam logic [7:0] OFF_HITHI = 8'h6C;        // Decoder query address high.
    localparam logic [7:0] OFF_HITKIND = 8'h70;      // Query kind; write launches decode.
    localparam logic [7:0] OFF_HITRES = 8'h74;       // Decode result.
    // --------------------------------------------------------------------
    // Field positions.
    // --------------------------------------------------------------------
    localparam int BCFG_EN = 0;                      // Window enable.
    localparam int BCFG_IO = 1;                      // I/O space window.
    localparam int BCFG_W64 = 2;                     // 64-bit memory window.
    localparam int BCFG_PF = 3;                      // Prefetchable.
    localparam int BCFG_SZ_LO = 8;                   // Size exponent low bit.
    localparam int DEVCTL_EXTTAG = 8;                // Extended tag enable bit.
    localparam int CAPS_EXTTAG = 5;                  // Extended tag capability bit.
    localparam int CAPS_PH_LO = 3;                   // Phantom functions field low bit.
    // --------------------------------------------------------------------
    // Limits and fixed values.
    // --------------------------------------------------------------------
    localparam logic [5:0] SZ_MIN_STD = 6'd7;        // 128 bytes.
    localparam logic [5:0] SZ_MIN_LEG = 6'd4;        // 16 bytes.
    localparam logic [5:0] SZ_MAX_32 = 6'd31;        // 2 gigabytes.
    localparam logic [5:0] SZ_MAX_64 = 6'd63;        // 8 exabytes.
    localparam logic [5:0] ROM_MIN = 6'd11;          // 2 KB.
    localparam logic [5:0] ROM_MAX = 6'd32;          // 4 GB.
    localparam logic [3:0] CAP_VERSION = 4'h2;       // Structure version, fixed.
    localparam logic [15:0] VID_RESERVED = 16'hFFFF;
    localparam logic [15:0] VID_DEFAULT = 16'h1234;  // Arbitrary value.
    localparam logic [15:0] DID_DEFAULT = 16'h5678;  // Arbitrary value.
    localparam logic [7:0] REV_DEFAULT = 8'h00;
    localparam logic [23:0] CLASS_DEFAULT = 24'h05_8000;
    localparam logic [31:0] CIS_DEFAULT = 32'h0000_0000;
    localparam logic [2:0] PHANTOM_DEFAULT = 3'd0;
    localparam logic [31:0] NOMAP_DATA = 32'h0000_0000;
    localparam logic [2:0] NOHIT = 3'd7;             // No BAR claimed.
    // --------------------------------------------------------------------
    // Types.
    // --------------------------------------------------------------------
    typedef enum logic [1:0] {
        PBH_MODE_EP = 2'b00,                         // Standard endpoint.
        PBH_MODE_LEG = 2'b01,                        // Legacy endpoint.
        PBH_MODE_RP = 2'b10                          // Root port.
    } pbh_mode_t;
    typedef struct packed {
        logic [5:0] sizeExp;                         // Window size as log2 bytes.
        logic pf;
        logic w64;
        logic io;
        logic en;
    } pbh_barcfg_t;
    typedef struct packed {
        logic valid;                                 // A window claimed the query.
        logic rom;                                   // The ROM window claimed it.
        logic [2:0] bar;                             // Claiming BAR index.
    } pbh_hit_t;
endpackage
`default_nettype wire

// ===== verilog/pbh_config_header.sv
// Function header fields, BAR and expansion ROM windows, and address decode, behind APB.
//
// Summary of operation
// - Endpoint: six 32-bit or three 64-bit BARs.
// - Root port: two 32-bit or one 64-bit.
// - 64-bit BAR swallows next slot as upper half.
// - I/O BARs 32-bit, nonprefetchable, legacy only.
// - 32-bit window power of two, max 2GB.
// - 64-bit window memory only, max 8EB.
// - Windows claim only their own space type.
// - Minimum window 128B standard, 16B legacy.
// - Prefetchable endpoint BARs except BAR5 are 64-bit.
// - ROM window sized between 2KB and 4GB.
// - Prefetchable windows have no read side effects.
// - Vendor id never reads all ones.
// - Revision id resets to zero.
// - Subsystem ids avoid zero.
// - Class code is three byte fields.
// - CIS pointer read-only, resets to zero.
// - Extended tag bit advertises 8 or 5 bits.
// - Option sets device control bit 8 at reset.
// - Phantom field counts borrowed function bits.
// - Capability version read-only and fixed.
// - BARs numbered zero to five, one word each.
`default_nettype none
module pbh_config_header #(
    parameter logic EXT_TAG_CAP = 1'b1,              // Advertise 8-bit tags.
    parameter logic EXT_TAG_DEFAULT = 1'b0,          // Reset value of device control bit 8.
    parameter logic [15:0] VENDOR_ID = pbh_pkg::VID_DEFAULT,
    parameter logic [15:0] DEVICE_ID = pbh_pkg::DID_DEFAULT,
    parameter logic [7:0] REVISION_ID = pbh_pkg::REV_DEFAULT,
    parameter logic [23:0] CLASS_CODE = pbh_pkg::CLASS_DEFAULT,
    parameter logic [31:0] CIS_POINTER = pbh_pkg::CIS_DEFAULT,
    parameter logic [2:0] PHANTOM_BITS = pbh_pkg::PHANTOM_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output pbh_pkg::pbh_hit_t hitResult,             // Last decode result.
    output logic extTagEnable                        // Device control bit 8.
);
    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    pbh_pkg::pbh_mode_t mode;                        // Port type chosen by software.
    pbh_pkg::pbh_barcfg_t barCfg [6];                // Effective, legalised window configs.
    logic [31:0] barBase [6];                        // Programmed base words.
    logic [31:0] romBase;                            // ROM base, bit 0 enables.
    logic [5:0] romSize;                             // ROM size exponent.
    logic [15:0] devCtl;                             // Device control register.
    logic [31:0] subsys;                             // Subsystem id and vendor id.
    logic [63:0] qAddr;                              // Decode query address.
    logic qIo;                                       // Query is I/O.
    logic qGo;                                       // Decode launched last cycle.
    logic access;                                    // Access phase of APB.
    logic [2:0] slot;                                // BAR slot from address.
    // The slave answers every access in its first access cycle.
    assign access = psel && penable;
    assign slot = 3'(paddr[4:2]);

    // Round a requested size into the legal range of the window kind.
    function automatic logic [5:0] clampSize(input logic [5:0] req, input logic [5:0] lo, input logic [5:0] hi);
        clampSize = (req < lo) ? lo : ((req > hi) ? hi : req);
    endfunction

    // Number of BAR slots a port type offers.
    function automatic logic [2:0] slotCount(input pbh_pkg::pbh_mode_t m);
        slotCount = (m == pbh_pkg::PBH_MODE_RP) ? 3'd2 : 3'd6;
    endfunction

    // Mask of address bits above the window size.
    function automatic logic [63:0] sizeMask(input logic [5:0] e);
        sizeMask = ~((64'h0000_0000_0000_0001 << e) - 64'h0000_0000_0000_0001);
    endfunction

    // Legalise a config word written by software into an effective config.
    function automatic pbh_pkg::pbh_barcfg_t legalise(input logic [31:0] w, input logic [2:0] n,
                                                       input pbh_pkg::pbh_mode_t m);
        pbh_pkg::pbh_barcfg_t c;
        logic [5:0] lo;
        c.en = w[pbh_pkg::BCFG_EN] && (n < slotCount(m));
        c.io = w[pbh_pkg::BCFG_IO] && (m == pbh_pkg::PBH_MODE_LEG);
        c.pf = w[pbh_pkg::BCFG_PF] && !c.io && !(m == pbh_pkg::PBH_MODE_EP && n[0] && n != 3'd5);
        // A 64-bit window needs a partner slot; BAR5 has none.
        c.w64 = !c.io && (n[0] == 1'b0) && (n < 3'd5) && (n + 3'd1 < slotCount(m))
                && (w[pbh_pkg::BCFG_W64] || (c.pf && m == pbh_pkg::PBH_MODE_EP));
        lo = (m == pbh_pkg::PBH_MODE_LEG) ? pbh_pkg::SZ_MIN_LEG : pbh_pkg::SZ_MIN_STD;
        c.sizeExp = clampSize(w[pbh_pkg::BCFG_SZ_LO +: 6], lo,
                              c.w64 ? pbh_pkg::SZ_MAX_64 : pbh_pkg::SZ_MAX_32);
        legalise = c;
    endfunction

    // Odd slot swallowed by a 64-bit lower partner.
    function automatic logic isUpper(input logic [2:0] n);
        isUpper = (n != 3'd0) && barCfg[n - 3'd1].en && barCfg[n - 3'd1].w64;
    endfunction

    // ------------------------------------------------------------------
    // Mode register.
    // ------------------------------------------------------------------
    // Changing the mode only takes effect for configs written afterwards.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode <= pbh_pkg::PBH_MODE_EP;
        end else if (access && pwrite && paddr == pbh_pkg::OFF_MODE && pwdata[1:0] != 2'b11) begin
            mode <= pbh_pkg::pbh_mode_t'(pwdata[1:0]);
        end
    end

    // ------------------------------------------------------------------
    // BAR configs and bases.
    // ------------------------------------------------------------------
    // A 64-bit window's upper slot holds the high base half; its own config is dead.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 6; i++) begin
                barCfg[i] <= '0;
                barBase[i] <= 32'h0000_0000;
            end
        end else if (access && pwrite && slot < 3'd6) begin
            if (paddr[7:5] == pbh_pkg::OFF_BARCFG0[7:5]) begin
                barCfg[slot] <= legalise(pwdata, slot, mode);
            end else if (paddr[7:5] == pbh_pkg::OFF_BAR0[7:5]) begin
                // Low bits under the window size stay zero so sizing reads back the mask.
                if (isUpper(slot)) begin
                    barBase[slot] <= pwdata & 32'(sizeMask(barCfg[slot - 3'd1].sizeExp) >> 32);
                end else begin
                    barBase[slot] <= pwdata & 32'(sizeMask(barCfg[slot].sizeExp));
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Expansion ROM window.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            romBase <= 32'h0000_0000;
            romSize <= pbh_pkg::ROM_MIN;
        end else if (access && pwrite && paddr == pbh_pkg::OFF_ROMCFG) begin
            romSize <= clampSize(pwdata[5:0], pbh_pkg::ROM_MIN, pbh_pkg::ROM_MAX);
        end else if (access && pwrite && paddr == pbh_pkg::OFF_ROM) begin
            romBase <= (pwdata & 32'(sizeMask(romSize))) | {31'h0, pwdata[0]};
        end
    end

    // ------------------------------------------------------------------
    // Device control and subsystem ids.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            devCtl <= {7'h00, EXT_TAG_DEFAULT, 8'h00};
            subsys <= {DEVICE_ID, VENDOR_ID};
        end else if (access && pwrite && paddr == pbh_pkg::OFF_DEVCTL) begin
            devCtl <= pwdata[15:0];
        end else if (access && pwrite && paddr == pbh_pkg::OFF_SUBSYS) begin
            // A half of zero is refused and the old half kept.
            subsys <= {(pwdata[31:16] == 16'h0000) ? subsys[31:16] : pwdata[31:16],
                       (pwdata[15:0] == 16'h0000) ? subsys[15:0] : pwdata[15:0]};
        end
    end

    // ------------------------------------------------------------------
    // Decode query.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            qAddr <= 64'h0;
            qIo <= 1'b0;
            qGo <= 1'b0;
        end else begin
            qGo <= access && pwrite && paddr == pbh_pkg::OFF_HITKIND;
            if (access && pwrite && paddr == pbh_pkg::OFF_HIT) begin
                qAddr[31:0] <= pwdata;
            end
            if (access && pwrite && paddr == pbh_pkg::OFF_HITHI) begin
                qAddr[63:32] <= pwdata;
            end
            if (access && pwrite && paddr == pbh_pkg::OFF_HITKIND) begin
                qIo <= pwdata[0];
            end
        end
    end

    // A ROM claim beats any BAR, else the lowest-numbered claiming BAR wins; reads of prefetchable windows change nothing.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hitResult <= '{valid: 1'b0, rom: 1'b0, bar: pbh_pkg::NOHIT};
        end else if (qGo) begin
            hitResult <= '{valid: 1'b0, rom: 1'b0, bar: pbh_pkg::NOHIT};
            for (int i = 5; i >= 0; i--) begin
                if (barCfg[i].en && !isUpper(3'(i)) && (barCfg[i].io == qIo)
                    && ((qAddr & sizeMask(barCfg[i].sizeExp)) == {barCfg[i].w64 ? barBase[i | 1] : 32'h0, barBase[i]})
                    && (barCfg[i].w64 || qAddr[63:32] == 32'h0)) begin
                    hitResult <= '{valid: 1'b1, rom: 1'b0, bar: 3'(i)};
                end
            end
            if (!qIo && romBase[0] && qAddr[63:32] == 32'h0
                && (qAddr[31:0] & 32'(sizeMask(romSize))) == {romBase[31:1], 1'b0}) begin
                hitResult <= '{valid: 1'b1, rom: 1'b1, bar: pbh_pkg::NOHIT};
            end
        end
    end

    // ------------------------------------------------------------------
    // APB read data and answer.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= pbh_pkg::NOMAP_DATA;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;     // Answer in the first access cycle.
            pslverr <= 1'b0;
            prdata <= pbh_pkg::NOMAP_DATA;
            if (psel && !penable && !pwrite) begin
                if (paddr[7:5] == pbh_pkg::OFF_BAR0[7:5] && slot < 3'd6) begin
                    // Disabled windows read as zero.
                    prdata <= isUpper(slot) ? barBase[slot] : !barCfg[slot].en ? 32'h0000_0000
                              : barBase[slot] | {28'h0, barCfg[slot].pf, barCfg[slot].w64, 1'b0, barCfg[slot].io};
                end else if (paddr[7:5] == pbh_pkg::OFF_BARCFG0[7:5] && slot < 3'd6) begin
                    prdata <= {18'h0, barCfg[slot].sizeExp, 4'h0, barCfg[slot].pf, barCfg[slot].w64,
                               barCfg[slot].io, barCfg[slot].en};
                end else begin
                    unique case (paddr)
                        pbh_pkg::OFF_IDENT:
                            prdata <= {DEVICE_ID, (VENDOR_ID == pbh_pkg::VID_RESERVED)
                                                  ? pbh_pkg::VID_DEFAULT : VENDOR_ID};
                        pbh_pkg::OFF_CLASS: prdata <= {CLASS_CODE[23:16], CLASS_CODE[15:8],
                                                       CLASS_CODE[7:0], REVISION_ID};
                        pbh_pkg::OFF_CIS: prdata <= CIS_POINTER;
                        pbh_pkg::OFF_CAPS:
                            prdata <= {12'h000, pbh_pkg::CAP_VERSION, 10'h000, EXT_TAG_CAP, PHANTOM_BITS[1:0], 3'h0};
                        pbh_pkg::OFF_DEVCTL: prdata <= {16'h0, devCtl};
                        pbh_pkg::OFF_MODE: prdata <= {30'h0, mode};
                        pbh_pkg::OFF_SUBSYS: prdata <= subsys;
                        pbh_pkg::OFF_ROM: prdata <= romBase;
                        pbh_pkg::OFF_ROMCFG: prdata <= {26'h0, romSize};
                        pbh_pkg::OFF_HIT: prdata <= qAddr[31:0];
                        pbh_pkg::OFF_HITHI: prdata <= qAddr[63:32];
                        pbh_pkg::OFF_HITKIND: prdata <= {31'h0, qIo};
                        pbh_pkg::OFF_HITRES: prdata <= {27'h0, hitResult};
                        default: pslverr <= 1'b1; // Unmapped address.
                    endcase
                end
            end else if (psel && !penable) begin
                pslverr <= !((paddr[7:5] == pbh_pkg::OFF_BAR0[7:5] || paddr[7:5] == pbh_pkg::OFF_BARCFG0[7:5])
                             && slot < 3'd6) && !(paddr inside {pbh_pkg::OFF_DEVCTL, pbh_pkg::OFF_MODE,
                             pbh_pkg::OFF_SUBSYS, pbh_pkg::OFF_ROM, pbh_pkg::OFF_ROMCFG, pbh_pkg::OFF_HIT,
                             pbh_pkg::OFF_HITHI, pbh_pkg::OFF_HITKIND, pbh_pkg::OFF_IDENT, pbh_pkg::OFF_CLASS,
                             pbh_pkg::OFF_CIS, pbh_pkg::OFF_CAPS, pbh_pkg::OFF_HITRES});
            end
        end
    end

    // Device control bit 8 drives the tag width used by the requester side.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            extTagEnable <= EXT_TAG_DEFAULT;
        end else begin
            extTagEnable <= devCtl[pbh_pkg::DEVCTL_EXTTAG] && EXT_TAG_CAP;
        end
    end
endmodule
`default_nettype wire

// ===== dv/pbh_config_header_monitor.sv
// Checker for the header block's bus, identity fields and decode result ports.
`default_nettype none
module pbh_config_header_monitor #(
    parameter logic EXT_TAG_CAP = 1'b1,
    parameter logic EXT_TAG_DEFAULT = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pbh_pkg::pbh_hit_t hitResult,
    input wire logic extTagEnable
);
    // ------------------------------------------------------------
    // Helpers: completing reads and writes, and the decode launch.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rd; // A read finishing at this edge.
    logic done; // A write finishing at this edge.
    logic kindWr; // A write that launches a decode.
    assign rd = psel && penable && pready && !pwrite;
    assign done = psel && penable && pready && pwrite;
    assign kindWr = done && paddr == pbh_pkg::OFF_HITKIND;
    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    a_ready_access: assert property (psel && !penable |=> pready) else $error("access not answered");
    a_err_unmapped: assert property (psel && penable && pready && paddr == 8'h7C |-> pslverr) else $error("no error");
    a_vid_legal: assert property (rd && paddr == pbh_pkg::OFF_IDENT |-> prdata[15:0] != pbh_pkg::VID_RESERVED)
        else $error("reserved vendor id");
    a_rev_zero: assert property (rd && paddr == pbh_pkg::OFF_CLASS |-> prdata[7:0] == 8'h00) else $error("revision");
    a_cis_zero: assert property (rd && paddr == pbh_pkg::OFF_CIS |-> prdata == 32'h0000_0000) else $error("cis");
    a_cap_fields: assert property (rd && paddr == pbh_pkg::OFF_CAPS |->
        prdata[19:16] == pbh_pkg::CAP_VERSION && prdata[5] == EXT_TAG_CAP) else $error("caps");
    a_tag_reset: assert property ($rose(rst_n) |-> extTagEnable == (EXT_TAG_DEFAULT & EXT_TAG_CAP))
        else $error("tag reset value");
    a_tag_clear: assert property (done && paddr == pbh_pkg::OFF_DEVCTL && !pwdata[8] |=> ##1 !extTagEnable)
        else $error("tag not cleared");
    a_nohit_code: assert property (!hitResult.valid |-> hitResult.bar == pbh_pkg::NOHIT) else $error("miss code");
    a_hit_timing: assert property (!$stable(hitResult) |-> $past(kindWr, 2)) else $error("result moved");
    // Main scenarios reached.
    c_hit: cover property (hitResult.valid);
    c_err: cover property (pslverr && pready);
    c_tag: cover property ($fell(extTagEnable));
endmodule
`default_nettype wire

// ===== dv/pbh_host_model.sv
// Bus master standing in for the link partner that sizes and programs the windows.
`default_nettype none
module pbh_host_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // One transfer; released address and data lines show the inverse so stale values never look valid.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the header block: identity fields, window legalising and decode.
`default_nettype none
`define CMP(g, x) begin checked++; if ((g) !== (x)) begin mismatches++; $display("mismatch %0t %h %h", $time, g, x); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, extTagEnable, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, b, q;
    pbh_pkg::pbh_hit_t hitResult;
    int mismatches = 0;
    int checked = 0;
    int seed = 32'h66ab4be6;
    initial forever #25 clk = ~clk;
    pbh_host_model u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    pbh_config_header #(.EXT_TAG_CAP(1'b1), .EXT_TAG_DEFAULT(1'b1)) u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hitResult(hitResult), .extTagEnable(extTagEnable));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        u_host.xfer(1'b0, a, 32'h0000_0000, rd, err);
        `CMP(rd & m, x & m)
    endtask
    // A decode result lands one edge after the edge that takes the launching write.
    task automatic query(input logic [31:0] lo, input logic [31:0] hi, input logic io);
        wr(pbh_pkg::OFF_HIT, lo);
        wr(pbh_pkg::OFF_HITHI, hi);
        wr(pbh_pkg::OFF_HITKIND, {31'h0, io});
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Expected claim of a 4 KB memory window in slot zero.
    function automatic pbh_pkg::pbh_hit_t exp_hit(input logic [31:0] base, input logic [31:0] a, input logic io);
        exp_hit = (a[31:12] == base[31:12] && !io) ? 5'b10_000 : {2'b00, pbh_pkg::NOHIT};
    endfunction
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #2_000_000;
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CMP(extTagEnable, 1'b1)
        rdchk(pbh_pkg::OFF_IDENT, 32'hFFFF_FFFF, {pbh_pkg::DID_DEFAULT, pbh_pkg::VID_DEFAULT});
        rdchk(pbh_pkg::OFF_CLASS, 32'hFFFF_FFFF, {pbh_pkg::CLASS_DEFAULT, 8'h00});
        wr(pbh_pkg::OFF_CIS, $random(seed));
        rdchk(pbh_pkg::OFF_CIS, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(pbh_pkg::OFF_CAPS, 32'hFFFF_FFFF);
        rdchk(pbh_pkg::OFF_CAPS, 32'h000F_0038, {12'h000, pbh_pkg::CAP_VERSION, 16'h0020});
        wr(pbh_pkg::OFF_DEVCTL, 32'h0000_0000);
        @(posedge clk) #1 `CMP(extTagEnable, 1'b0)
        wr(pbh_pkg::OFF_DEVCTL, 32'h0000_0100);
        @(posedge clk) #1 `CMP(extTagEnable, 1'b1)
        wr(pbh_pkg::OFF_SUBSYS, 32'hA5A5_5A5A);
        wr(pbh_pkg::OFF_SUBSYS, 32'h0000_0000);
        rdchk(pbh_pkg::OFF_SUBSYS, 32'hFFFF_FFFF, 32'hA5A5_5A5A);
        u_host.xfer(1'b0, 8'h7C, 32'h0000_0000, rd, err);
        `CMP(err, 1'b1)
        $display("identity tests done");
        for (int m = 0; m < 2; m++) begin
            wr(pbh_pkg::OFF_MODE, m);
            wr(pbh_pkg::OFF_BARCFG0, 32'h0000_0203);
            rdchk(pbh_pkg::OFF_BARCFG0, 32'h0000_3F0F, m ? 32'h0000_0403 : 32'h0000_0701);
        end
        wr(pbh_pkg::OFF_MODE, 32'h0000_0000);
        wr(pbh_pkg::OFF_BARCFG0, 32'h0000_2801);
        rdchk(pbh_pkg::OFF_BARCFG0, 32'h0000_3F0F, 32'h0000_1F01);
        wr(pbh_pkg::OFF_BARCFG0, 32'h0000_0C09);
        rdchk(pbh_pkg::OFF_BARCFG0, 32'h0000_3F0F, 32'h0000_0C0D);
        wr(pbh_pkg::OFF_BARCFG0 + 8'h14, 32'h0000_0C09);
        rdchk(pbh_pkg::OFF_BARCFG0 + 8'h14, 32'h0000_3F0F, 32'h0000_0C09);
        wr(pbh_pkg::OFF_ROMCFG, 32'h0000_0005);
        rdchk(pbh_pkg::OFF_ROMCFG, 32'h0000_003F, 32'h0000_000B);
        wr(pbh_pkg::OFF_ROMCFG, 32'h0000_0028);
        rdchk(pbh_pkg::OFF_ROMCFG, 32'h0000_003F, 32'h0000_0020);
        wr(pbh_pkg::OFF_MODE, 32'h0000_0002);
        wr(pbh_pkg::OFF_BARCFG0 + 8'h08, 32'h0000_0C01);
        rdchk(pbh_pkg::OFF_BARCFG0 + 8'h08, 32'hFFFF_FFFF, 32'h0000_0C00);
        wr(pbh_pkg::OFF_MODE, 32'h0000_0000);
        wr(pbh_pkg::OFF_BARCFG0 + 8'h14, 32'h0000_0000);
        wr(pbh_pkg::OFF_BARCFG0, 32'h0000_3F05);
        rdchk(pbh_pkg::OFF_BARCFG0, 32'h0000_3F0F, 32'h0000_3F05);
        $display("window setup tests done");
        wr(pbh_pkg::OFF_BARCFG0, 32'h0000_0C01);
        for (int i = 0; i < 12; i++) begin
            b = $random(seed) & 32'hFFFF_F000;
            q = (i % 3 == 0) ? $random(seed) : (b | ($random(seed) & 32'h0000_0FFF));
            wr(pbh_pkg::OFF_BAR0, b);
            rdchk(pbh_pkg::OFF_BAR0, 32'hFFFF_FFFF, b);
            query(q, 32'h0000_0000, i % 4 == 1);
            `CMP(hitResult, exp_hit(b, q, i % 4 == 1))
        end
        wr(pbh_pkg::OFF_BARCFG0, 32'h0000_0C05);
        wr(pbh_pkg::OFF_BAR0 + 8'h04, 32'h0000_0001);
        query(b, 32'h0000_0000, 1'b0);
        `CMP(hitResult.valid, 1'b0)
        query(b, 32'h0000_0001, 1'b0);
        `CMP(hitResult, 5'b10_000)
        wr(pbh_pkg::OFF_BARCFG0, 32'h0000_0000);
        rdchk(pbh_pkg::OFF_BAR0, 32'hFFFF_FFFF, 32'h0000_0000);
        query(b, 32'h0000_0000, 1'b0);
        `CMP(hitResult, {2'b00, pbh_pkg::NOHIT})
        wr(pbh_pkg::OFF_ROMCFG, 32'h0000_000B);
        wr(pbh_pkg::OFF_ROM, {b[31:11], 11'h001});
        query({b[31:11], 11'h7FC}, 32'h0000_0000, 1'b0);
        `CMP(hitResult, {2'b11, pbh_pkg::NOHIT})
        $display("decode tests done");
        complete_run();
    end
endmodule
bind pbh_config_header pbh_config_header_monitor #(.EXT_TAG_CAP(EXT_TAG_CAP), .EXT_TAG_DEFAULT(EXT_TAG_DEFAULT))
    u_mon (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hitResult(hitResult),
    .extTagEnable(extTagEnable));
`default_nettype wire
